// *** smc_pkg.sv ***
// package: register map, field positions and reset values for the supply monitor and comparator
// How it works
// [RULE1] supply-low flag sets when supply drops
// [RULE2] write one clears flag once supply high
// [RULE3] clear allowed same cycle supply returns high
// [RULE4] bit 3 reads live supply comparator state; reads 1 while the supply watch is disabled
// [RULE5] bit 2 picks trip threshold level
// [RULE6] bit 1 enables the supply watch circuit
// [RULE7] supply-low flag offered as interrupt source
// [RULE8] control bit 10 enables the comparator
// [RULE9] bits 9:8 select negative input
// [RULE10] bits 7:6 route comparator output
// [RULE11] bit 5 inverts comparator output polarity
// [RULE12] bits 4:3 select response speed
// [RULE13] bit 2 enables input hysteresis
// [RULE14] rising edge sets sticky flag, write-one clears
// [RULE15] falling edge sets sticky flag, write-one clears
// [RULE16] result feeds irq, logic array, adc, pin
// [RULE17] key 0x9A, config write, key 0x0C sequence
// [RULE18] flags update only when enabled, inputs synchronised
`default_nettype none
package smc_pkg;
    localparam logic [31:0] SUPPLY_MONITOR_CONTROL_ADDR = 32'hFFFF0440;
    localparam logic [31:0] COMPARATOR_CONTROL_ADDR     = 32'hFFFF0444;
    localparam logic [31:0] DAC_BUFFER_KEY_FIRST_ADDR   = 32'hFFFF0650;
    localparam logic [31:0] DAC_BUFFER_CONFIG_ADDR      = 32'hFFFF0654;
    localparam logic [31:0] DAC_BUFFER_KEY_SECOND_ADDR  = 32'hFFFF0658;
    localparam logic [15:0] SUPPLY_MONITOR_RESET        = 16'h0008;
    localparam logic [15:0] COMPARATOR_RESET            = 16'h0000;
    localparam logic [7:0]  DAC_BUFFER_CONFIG_RESET     = 8'h00;
    localparam logic [7:0]  DAC_KEY_FIRST_CODE          = 8'h9A;
    localparam logic [7:0]  DAC_KEY_SECOND_CODE         = 8'h0C;
    localparam logic [3:0]  DAC_BUFFER_CONFIG_MASK      = 4'hF;
    // supply monitor fields
    localparam int SM_FLAG_BIT    = 0;
    localparam int SM_ENABLE_BIT  = 1;
    localparam int SM_TRIP_BIT    = 2;
    localparam int SM_STATE_BIT   = 3;
    // comparator fields
    localparam int CMP_FALL_BIT   = 0;
    localparam int CMP_RISE_BIT   = 1;
    localparam int CMP_HYST_BIT   = 2;
    localparam int CMP_RESP_LO    = 3;
    localparam int CMP_RESP_HI    = 4;
    localparam int CMP_POL_BIT    = 5;
    localparam int CMP_ROUTE_LO   = 6;
    localparam int CMP_ROUTE_HI   = 7;
    localparam int CMP_NEG_LO     = 8;
    localparam int CMP_NEG_HI     = 9;
    localparam int CMP_ENABLE_BIT = 10;
    localparam logic [1:0] ROUTE_TO_PIN = 2'b10;
    localparam logic [1:0] ROUTE_TO_IRQ = 2'b11;
    localparam logic [1:0] HTRANS_IDLE  = 2'b00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ   = 2'b11;

    typedef enum logic [1:0] {
        KEY_IDLE    = 2'b00,
        KEY_ARMED   = 2'b01,
        KEY_WRITTEN = 2'b10
    } smc_key_state_t;
endpackage : smc_pkg
`default_nettype wire

// *** smc_edge_sync.sv ***
// two-flop synchroniser with rise and fall detection, gated by an enable
`timescale 1ns/100ps
`default_nettype none
module smc_edge_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    input  wire logic enable,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= async_in; // RULE18
            sync_q <= meta_q;
        end
    end

    // the history follows the input even while disabled so enabling never fakes an edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 1'b1;
        end else begin
            last_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = enable & sync_q & ~last_q; // RULE18
    assign fall  = enable & ~sync_q & last_q; // RULE18
endmodule : smc_edge_sync
`default_nettype wire

// *** smc_regs.sv ***
// register bank for supply watch, comparator control and dac buffer key guard
`timescale 1ns/100ps
`default_nettype none
module smc_regs (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // analog supply watch
    input  wire logic        SUPPLY_ABOVE_TRIP_STATE,
    output logic             SUPPLY_WATCH_ENABLE,
    output logic             TRIP_LEVEL_SELECT,
    output logic             SUPPLY_LOW_IRQ,
    // analog comparator
    input  wire logic        COMPARATOR_RAW,
    output logic             COMPARATOR_ENABLE,
    output logic [1:0]       NEGATIVE_INPUT_SELECT,
    output logic [1:0]       RESPONSE_SPEED_SELECT,
    output logic             HYSTERESIS_ENABLE,
    output logic             COMPARATOR_RESULT_PIN,
    output logic             COMPARATOR_IRQ,
    output logic             COMPARATOR_TO_LOGIC_ARRAY,
    output logic             COMPARATOR_ADC_TRIGGER,
    // dac buffer op amp mode
    output logic [3:0]       DAC_BUFFER_CONFIG
);
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [31:0] addr_q;
    logic [15:0] wdata;
    logic        sm_wr;
    logic        cmp_wr;
    logic        key1_wr;
    logic        cfg_wr;
    logic        key2_wr;

    logic        sm_enable_q;
    logic        sm_trip_q;
    logic        sm_flag_q;
    logic        cmp_enable_q;
    logic [1:0]  cmp_neg_q;
    logic [1:0]  cmp_route_q;
    logic        cmp_pol_q;
    logic [1:0]  cmp_resp_q;
    logic        cmp_hyst_q;
    logic        cmp_rise_q;
    logic        cmp_fall_q;
    logic [3:0]  dac_cfg_q;
    logic [3:0]  dac_cfg_shadow_q;
    logic        cmp_out_q;
    smc_pkg::smc_key_state_t key_state_q;

    logic        supply_level;
    logic        supply_fall;
    logic        cmp_level;
    logic        cmp_rise;
    logic        cmp_fall;
    logic        cmp_result;

    // a transfer is taken when the slave is selected, the bus is ready and HTRANS is NONSEQ or SEQ
    function automatic logic is_active(input logic [1:0] trans);
        is_active = (trans == smc_pkg::HTRANS_NONSEQ) || (trans == smc_pkg::HTRANS_SEQ);
    endfunction : is_active

    // zero wait states: every data phase completes in one cycle, always okay
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 32'h00000000;
        end else if (HREADY) begin
            wr_pend_q <= HSEL & is_active(HTRANS) & HWRITE;
            rd_pend_q <= HSEL & is_active(HTRANS) & ~HWRITE;
            addr_q    <= HADDR;
        end
    end

    assign wdata = HWDATA[15:0];

    // data-phase write strobes, decoded from the held address
    always_comb begin
        sm_wr   = 1'b0;
        cmp_wr  = 1'b0;
        key1_wr = 1'b0;
        cfg_wr  = 1'b0;
        key2_wr = 1'b0;
        if (wr_pend_q && addr_q == smc_pkg::SUPPLY_MONITOR_CONTROL_ADDR) begin
            sm_wr = 1'b1;
        end else if (wr_pend_q && addr_q == smc_pkg::COMPARATOR_CONTROL_ADDR) begin
            cmp_wr = 1'b1;
        end else if (wr_pend_q && addr_q == smc_pkg::DAC_BUFFER_KEY_FIRST_ADDR) begin
            key1_wr = 1'b1;
        end else if (wr_pend_q && addr_q == smc_pkg::DAC_BUFFER_CONFIG_ADDR) begin
            cfg_wr = 1'b1;
        end else if (wr_pend_q && addr_q == smc_pkg::DAC_BUFFER_KEY_SECOND_ADDR) begin
            key2_wr = 1'b1;
        end
    end

    smc_edge_sync u_supply_sync (
        .clk      (REF_CLK),
        .rst_n    (RSTN),
        .async_in (SUPPLY_ABOVE_TRIP_STATE),
        .enable   (sm_enable_q),
        .level    (supply_level),
        .rise     (),
        .fall     (supply_fall)
    );

    smc_edge_sync u_cmp_sync (
        .clk      (REF_CLK),
        .rst_n    (RSTN),
        .async_in (COMPARATOR_RAW),
        .enable   (cmp_enable_q),
        .level    (cmp_level),
        .rise     (cmp_rise),
        .fall     (cmp_fall)
    );

    // supply watch configuration
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sm_enable_q <= smc_pkg::SUPPLY_MONITOR_RESET[smc_pkg::SM_ENABLE_BIT];
            sm_trip_q   <= smc_pkg::SUPPLY_MONITOR_RESET[smc_pkg::SM_TRIP_BIT];
        end else if (sm_wr) begin
            sm_enable_q <= wdata[smc_pkg::SM_ENABLE_BIT]; // RULE6
            sm_trip_q   <= wdata[smc_pkg::SM_TRIP_BIT]; // RULE5
        end
    end

    // supply-low flag: set wins over a clear in the same cycle
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sm_flag_q <= smc_pkg::SUPPLY_MONITOR_RESET[smc_pkg::SM_FLAG_BIT];
        end else if (supply_fall) begin
            sm_flag_q <= 1'b1; // RULE1
        end else if (sm_wr && wdata[smc_pkg::SM_FLAG_BIT] && supply_level) begin
            sm_flag_q <= 1'b0; // RULE2 RULE3
        end
    end

    // comparator configuration
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cmp_enable_q <= smc_pkg::COMPARATOR_RESET[smc_pkg::CMP_ENABLE_BIT];
            cmp_neg_q    <= smc_pkg::COMPARATOR_RESET[smc_pkg::CMP_NEG_HI:smc_pkg::CMP_NEG_LO];
            cmp_route_q  <= smc_pkg::COMPARATOR_RESET[smc_pkg::CMP_ROUTE_HI:smc_pkg::CMP_ROUTE_LO];
            cmp_pol_q    <= smc_pkg::COMPARATOR_RESET[smc_pkg::CMP_POL_BIT];
            cmp_resp_q   <= smc_pkg::COMPARATOR_RESET[smc_pkg::CMP_RESP_HI:smc_pkg::CMP_RESP_LO];
            cmp_hyst_q   <= smc_pkg::COMPARATOR_RESET[smc_pkg::CMP_HYST_BIT];
        end else if (cmp_wr) begin
            cmp_enable_q <= wdata[smc_pkg::CMP_ENABLE_BIT]; // RULE8
            cmp_neg_q    <= wdata[smc_pkg::CMP_NEG_HI:smc_pkg::CMP_NEG_LO]; // RULE9
            cmp_route_q  <= wdata[smc_pkg::CMP_ROUTE_HI:smc_pkg::CMP_ROUTE_LO]; // RULE10
            cmp_pol_q    <= wdata[smc_pkg::CMP_POL_BIT]; // RULE11
            cmp_resp_q   <= wdata[smc_pkg::CMP_RESP_HI:smc_pkg::CMP_RESP_LO]; // RULE12
            cmp_hyst_q   <= wdata[smc_pkg::CMP_HYST_BIT]; // RULE13
        end
    end

    // edge flags follow the raw comparison, before polarity
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cmp_rise_q <= smc_pkg::COMPARATOR_RESET[smc_pkg::CMP_RISE_BIT];
        end else if (cmp_rise) begin
            cmp_rise_q <= 1'b1; // RULE14
        end else if (cmp_wr && wdata[smc_pkg::CMP_RISE_BIT]) begin
            cmp_rise_q <= 1'b0; // RULE14
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cmp_fall_q <= smc_pkg::COMPARATOR_RESET[smc_pkg::CMP_FALL_BIT];
        end else if (cmp_fall) begin
            cmp_fall_q <= 1'b1; // RULE15
        end else if (cmp_wr && wdata[smc_pkg::CMP_FALL_BIT]) begin
            cmp_fall_q <= 1'b0; // RULE15
        end
    end

    // a disabled comparator presents a quiet low result
    assign cmp_result = cmp_enable_q & (cmp_level ^ cmp_pol_q); // RULE11

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cmp_out_q <= 1'b0;
        end else begin
            cmp_out_q <= cmp_result;
        end
    end

    // key sequence: key one, then config, then key two commits
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            key_state_q      <= smc_pkg::KEY_IDLE;
            dac_cfg_shadow_q <= smc_pkg::DAC_BUFFER_CONFIG_RESET[3:0];
            dac_cfg_q        <= smc_pkg::DAC_BUFFER_CONFIG_RESET[3:0];
        end else if (wr_pend_q) begin
            case (key_state_q)
                smc_pkg::KEY_IDLE: begin
                    if (key1_wr && wdata[7:0] == smc_pkg::DAC_KEY_FIRST_CODE) begin
                        key_state_q <= smc_pkg::KEY_ARMED; // RULE17
                    end
                end
                smc_pkg::KEY_ARMED: begin
                    if (cfg_wr) begin
                        dac_cfg_shadow_q <= wdata[3:0] & smc_pkg::DAC_BUFFER_CONFIG_MASK;
                        key_state_q      <= smc_pkg::KEY_WRITTEN; // RULE17
                    end else begin
                        key_state_q <= smc_pkg::KEY_IDLE;
                    end
                end
                smc_pkg::KEY_WRITTEN: begin
                    if (key2_wr && wdata[7:0] == smc_pkg::DAC_KEY_SECOND_CODE) begin
                        dac_cfg_q <= dac_cfg_shadow_q; // RULE17
                    end
                    key_state_q <= smc_pkg::KEY_IDLE;
                end
                default: begin
                    key_state_q <= smc_pkg::KEY_IDLE;
                end
            endcase
        end
    end

    // read data registered at the address phase, so it stands in the data phase
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            HRDATA <= 32'h00000000;
        end else if (HREADY && HSEL && is_active(HTRANS) && !HWRITE) begin
            if (HADDR == smc_pkg::SUPPLY_MONITOR_CONTROL_ADDR) begin
                HRDATA <= {28'h0000000, supply_level | ~sm_enable_q, // RULE4
                           sm_trip_q, sm_enable_q, sm_flag_q};
            end else if (HADDR == smc_pkg::COMPARATOR_CONTROL_ADDR) begin
                HRDATA <= {21'h000000, cmp_enable_q, cmp_neg_q, cmp_route_q,
                           cmp_pol_q, cmp_resp_q, cmp_hyst_q, cmp_rise_q, cmp_fall_q};
            end else if (HADDR == smc_pkg::DAC_BUFFER_CONFIG_ADDR) begin
                HRDATA <= {28'h0000000, dac_cfg_q};
            end else begin
                HRDATA <= 32'h00000000;
            end
        end
    end

    assign SUPPLY_WATCH_ENABLE       = sm_enable_q;
    assign TRIP_LEVEL_SELECT         = sm_trip_q;
    assign SUPPLY_LOW_IRQ            = sm_flag_q; // RULE7
    assign COMPARATOR_ENABLE         = cmp_enable_q;
    assign NEGATIVE_INPUT_SELECT     = cmp_neg_q;
    assign RESPONSE_SPEED_SELECT     = cmp_resp_q;
    assign HYSTERESIS_ENABLE         = cmp_hyst_q;
    assign COMPARATOR_RESULT_PIN     = cmp_out_q & (cmp_route_q == smc_pkg::ROUTE_TO_PIN); // RULE10 RULE16
    assign COMPARATOR_IRQ            = (cmp_route_q == smc_pkg::ROUTE_TO_IRQ) &
                                       (cmp_rise_q | cmp_fall_q); // RULE16
    assign COMPARATOR_TO_LOGIC_ARRAY = cmp_out_q; // RULE16
    assign COMPARATOR_ADC_TRIGGER    = cmp_out_q; // RULE16
    assign DAC_BUFFER_CONFIG         = dac_cfg_q;
endmodule : smc_regs
`default_nettype wire

// *** smc_checker.sv ***
// checker: timing relations between the supply watch and comparator outputs
`timescale 1ns/100ps
`default_nettype none
module smc_checker (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic SUPPLY_ABOVE_TRIP_STATE,
    input wire logic SUPPLY_WATCH_ENABLE,
    input wire logic SUPPLY_LOW_IRQ,
    input wire logic COMPARATOR_ENABLE,
    input wire logic COMPARATOR_RESULT_PIN,
    input wire logic COMPARATOR_IRQ,
    input wire logic COMPARATOR_TO_LOGIC_ARRAY,
    input wire logic COMPARATOR_ADC_TRIGGER
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    // two sync flops and an edge stage sit in front of the flag, hence the slack
    sequence s_drop;
        SUPPLY_WATCH_ENABLE && $fell(SUPPLY_ABOVE_TRIP_STATE) ##1
            (SUPPLY_WATCH_ENABLE && !SUPPLY_ABOVE_TRIP_STATE) [*3];
    endsequence
    sequence s_low;
        (SUPPLY_LOW_IRQ && !SUPPLY_ABOVE_TRIP_STATE) [*3];
    endsequence
    property p_set;
        s_drop |-> ##[0:2] SUPPLY_LOW_IRQ;
    endproperty
    property p_hold;
        s_low |=> SUPPLY_LOW_IRQ;
    endproperty
    property p_clr;
        $fell(SUPPLY_LOW_IRQ) |-> $past(SUPPLY_ABOVE_TRIP_STATE, 3);
    endproperty
    property p_en;
        $rose(SUPPLY_LOW_IRQ) |-> SUPPLY_WATCH_ENABLE || $past(SUPPLY_WATCH_ENABLE);
    endproperty
    property p_off;
        !COMPARATOR_ENABLE [*5] |-> !COMPARATOR_TO_LOGIC_ARRAY;
    endproperty
    property p_fan;
        COMPARATOR_ADC_TRIGGER == COMPARATOR_TO_LOGIC_ARRAY;
    endproperty
    property p_pin;
        COMPARATOR_RESULT_PIN |-> COMPARATOR_TO_LOGIC_ARRAY;
    endproperty
    property p_irq;
        $rose(COMPARATOR_IRQ) |-> COMPARATOR_ENABLE;
    endproperty
    property p_bus;
        HREADYOUT && !HRESP;
    endproperty
    a_set: assert property (p_set) else $error("supply flag not set");
    a_hold: assert property (p_hold) else $error("supply flag lost");
    a_clr: assert property (p_clr) else $error("supply flag cleared while low");
    a_en: assert property (p_en) else $error("supply flag set while off");
    a_off: assert property (p_off) else $error("result while disabled");
    a_fan: assert property (p_fan) else $error("result fan-out differs");
    a_pin: assert property (p_pin) else $error("pin without result");
    a_irq: assert property (p_irq) else $error("edge flag while disabled");
    a_bus: assert property (p_bus) else $error("bus not ready or error");
endmodule : smc_checker
bind smc_regs smc_checker u_smc_checker (.REF_CLK, .RSTN, .HREADYOUT, .HRESP,
    .SUPPLY_ABOVE_TRIP_STATE, .SUPPLY_WATCH_ENABLE, .SUPPLY_LOW_IRQ, .COMPARATOR_ENABLE,
    .COMPARATOR_RESULT_PIN, .COMPARATOR_IRQ, .COMPARATOR_TO_LOGIC_ARRAY,
    .COMPARATOR_ADC_TRIGGER);
`default_nettype wire

// *** supply_monitor_comparator_ctrl_tb.sv ***
// testbench: bus access, supply watch, comparator and dac key sequence
`timescale 1ns/100ps
`default_nettype none
module supply_monitor_comparator_ctrl_tb;
    localparam logic [31:0] A_SM  = smc_pkg::SUPPLY_MONITOR_CONTROL_ADDR;
    localparam logic [31:0] A_CMP = smc_pkg::COMPARATOR_CONTROL_ADDR;
    localparam logic [31:0] A_K1  = smc_pkg::DAC_BUFFER_KEY_FIRST_ADDR;
    localparam logic [31:0] A_K2  = smc_pkg::DAC_BUFFER_KEY_SECOND_ADDR;
    localparam logic [31:0] A_CF  = smc_pkg::DAC_BUFFER_CONFIG_ADDR;
    logic        clk, rst_n, hwrite, hready, hresp, sup_st, sup_en, trip, sup_irq;
    logic        raw, cmp_en, hyst, pin, cmp_irq, pla, adc;
    logic [1:0]  htrans, neg, resp;
    logic [3:0]  dcfg;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          fails = 0;
    int          n_checks = 0;
    smc_regs u_smc_regs (
        .REF_CLK(clk), .RSTN(rst_n), .HSEL(1'h1), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .SUPPLY_ABOVE_TRIP_STATE(sup_st), .SUPPLY_WATCH_ENABLE(sup_en),
        .TRIP_LEVEL_SELECT(trip), .SUPPLY_LOW_IRQ(sup_irq), .COMPARATOR_RAW(raw),
        .COMPARATOR_ENABLE(cmp_en), .NEGATIVE_INPUT_SELECT(neg),
        .RESPONSE_SPEED_SELECT(resp), .HYSTERESIS_ENABLE(hyst),
        .COMPARATOR_RESULT_PIN(pin), .COMPARATOR_IRQ(cmp_irq),
        .COMPARATOR_TO_LOGIC_ARRAY(pla), .COMPARATOR_ADC_TRIGGER(adc),
        .DAC_BUFFER_CONFIG(dcfg));
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_rdy;
        int i;
        i = 0;
        @(posedge clk);
        while (hready !== 1'h1) begin
            i++;
            if (i > 50) begin
                fails++;
                finish_test;
            end
            @(posedge clk);
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [31:0] a, d);
        htrans <= smc_pkg::HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= w;
        wait_rdy;
        htrans <= smc_pkg::HTRANS_IDLE;
        hwdata <= w ? d : 32'h0;
        wait_rdy;
        rd = hrdata;
    endtask : bus
    // the extra edge lets the write land before any output is looked at
    task automatic wr(input logic [31:0] a, d);
        bus(1'h1, a, d);
        @(posedge clk);
    endtask : wr
    task automatic rdc(input logic [31:0] a, exp);
        bus(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic t_reset;
        rdc(A_SM, 32'h8);
        rdc(A_CMP, 32'h0);
        rdc(A_K1, 32'h0);
        rdc(A_CF, 32'h0);
        wr(32'hFFFF0448, 32'hFFFF);
        rdc(32'hFFFF0448, 32'h0);
        chk(sup_irq, 1'h0);
        chk(hresp, 1'h0);
    endtask : t_reset
    task automatic t_supply;
        @(posedge clk) sup_st <= 1'h1;
        repeat (4) @(posedge clk);
        wr(A_SM, 32'h6);
        chk({sup_en, trip}, 2'h3);
        rdc(A_SM, 32'hE);
        @(posedge clk) sup_st <= 1'h0;
        repeat (6) @(posedge clk);
        chk(sup_irq, 1'h1);
        rdc(A_SM, 32'h7);
        wr(A_SM, 32'h7);
        rdc(A_SM, 32'h7);
        @(posedge clk) sup_st <= 1'h1;
        repeat (3) @(posedge clk);
        wr(A_SM, 32'h6);
        rdc(A_SM, 32'hF);
        wr(A_SM, 32'h3);
        rdc(A_SM, 32'hA);
        chk({sup_en, trip}, 2'h2);
        wr(A_SM, 32'h0);
        @(posedge clk) sup_st <= 1'h0;
        repeat (6) @(posedge clk);
        rdc(A_SM, 32'h8);
    endtask : t_supply
    task automatic t_cmp;
        logic [31:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {22'h0, i[1:0], 3'h0, {2{i[0]}}, i[1], 2'h0};
            wr(A_CMP, v);
            chk({neg, resp}, {i[1:0], {2{i[0]}}});
            chk(hyst, i[1]);
            rdc(A_CMP, v);
        end
        wr(A_CMP, 32'h480);
        chk(cmp_en, 1'h1);
        @(posedge clk) raw <= 1'h1;
        repeat (6) @(posedge clk);
        chk({pin, pla, adc}, 3'h7);
        rdc(A_CMP, 32'h482);
        @(posedge clk) raw <= 1'h0;
        repeat (6) @(posedge clk);
        chk({pin, pla}, 2'h0);
        rdc(A_CMP, 32'h483);
        wr(A_CMP, 32'h4A0);
        repeat (3) @(posedge clk);
        chk(pla, 1'h1);
        wr(A_CMP, 32'h4E0);
        chk({cmp_irq, pin}, 2'h2);
        wr(A_CMP, 32'h4E3);
        rdc(A_CMP, 32'h4E0);
        chk(cmp_irq, 1'h0);
        wr(A_CMP, 32'h0);
        @(posedge clk) raw <= 1'h1;
        repeat (6) @(posedge clk);
        chk(pla, 1'h0);
        rdc(A_CMP, 32'h0);
    endtask : t_cmp
    task automatic t_key;
        wr(A_K1, 32'h9A);
        wr(A_CF, 32'h5);
        wr(A_K2, 32'h0C);
        chk(dcfg, 4'h5);
        rdc(A_CF, 32'h5);
        wr(A_K1, 32'h9A);
        wr(A_CF, 32'hA);
        wr(A_K2, 32'h0D);
        rdc(A_CF, 32'h5);
        wr(A_CF, 32'hA);
        wr(A_K2, 32'h0C);
        chk(dcfg, 4'h5);
    endtask : t_key
    initial begin
        rst_n = 1'h0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        sup_st = 1'h0;
        raw = 1'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        t_reset;
        t_supply;
        t_cmp;
        t_key;
        finish_test;
    end
    initial begin
        #1000000;
        fails++;
        finish_test;
    end
endmodule : supply_monitor_comparator_ctrl_tb
`default_nettype wire
